// File: bbk_consts.svh
// register offsets, field positions and reset values of the backup storage bank
`ifndef BBK_CONSTS_SVH
`define BBK_CONSTS_SVH

`define BBK_ADDR_WIDTH 4
`define BBK_OFF_BANK_FIRST 4'h0
`define BBK_OFF_CTRL 4'h8
`define BBK_OFF_STAT 4'h9

`define BBK_CTRL_CLR_ALLOW_BIT 0
`define BBK_CTRL_CLR_ALLOW_RESET 1'b1

`define BBK_STAT_BLOCKED_BIT 0
`define BBK_STAT_TAMPER_BIT 1
`define BBK_STAT_CLEARED_BIT 2
`define BBK_STAT_CLR_ENABLE_BIT 3
`define BBK_STAT_PIN_ZERO_EN_BIT 4
`define BBK_STAT_PIN_ONE_EN_BIT 5
`define BBK_STAT_PERIOD_SET_BIT 6
`define BBK_STAT_DBC_STATUS_ZERO_BIT 7
`define BBK_STAT_DBC_STATUS_ONE_BIT 8
`define BBK_STAT_DROP_COUNT_LSB 16
`define BBK_DROP_COUNT_WIDTH 8
`define BBK_DROP_COUNT_MAX 8'hff

`endif

// File: bbk_pkg.sv
// types shared by the backup storage bank
`default_nettype none
package bbk_pkg;

	typedef logic [3:0] bbk_addr_t;

	typedef enum logic [1:0] {
		BBK_ACC_BANK = 2'b00,
		BBK_ACC_CTRL = 2'b01,
		BBK_ACC_STAT = 2'b10,
		BBK_ACC_NONE = 2'b11
	} bbk_acc_e;

	typedef struct packed {
		logic tamper_seen;
		logic blocked;
		logic clr_allow;
		logic clear_seen;
		logic clear_pulse;
		logic [7:0] drop_count;
	} bbk_top_s;

endpackage

`default_nettype wire

// File: bbk_store.sv
// word store of the backup bank with lower-half clear and registered read data
`timescale 1ns/1ns
`default_nettype none

module bbk_store #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic clr_low,
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	input wire logic alt_sel,
	input wire logic [WIDTH-1:0] alt_data,
	output logic [WIDTH-1:0] rd_data
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0] rd_data;
	} bbk_store_s;

	bbk_store_s cur;
	bbk_store_s next_cur;

	generate
		if (DEPTH < 2 || (DEPTH % 2) != 0 || DEPTH > (1 << AW) || WIDTH < 1) begin : g_bad
			$error("bbk_store: unsupported depth or width");
		end
	endgenerate

	always_comb begin
		next_cur = cur;
		// read data stand only in the cycle after the read strobe
		next_cur.rd_data = '0;
		if (rd_en) begin
			next_cur.rd_data = alt_sel ? alt_data : cur.mem[rd_addr];
		end
		for (int i = 0; i < DEPTH; i++) begin
			if (clr_low && i < DEPTH / 2) begin
				next_cur.mem[i] = '0;
			end else if (wr_en && wr_addr == AW'(i)) begin
				next_cur.mem[i] = wr_data;
			end
		end
		// stored words are retained across reset
		if (rst) begin
			next_cur.rd_data = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (ce) begin
			cur <= next_cur;
		end
	end

	assign rd_data = cur.rd_data;

endmodule

`default_nettype wire

// File: bbk_backup_bank.sv
// backup storage bank: eight retained words with debounce clear and tamper write lock
`timescale 1ns/1ns
`default_nettype none
`include "bbk_consts.svh"

module bbk_backup_bank #(
	parameter int DATA_WIDTH = 32,
	parameter int NUM_REGS = 8,
	parameter int PERIOD_WIDTH = 3
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	input wire logic [`BBK_ADDR_WIDTH-1:0] ADDR,
	input wire logic [DATA_WIDTH-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [DATA_WIDTH-1:0] RDATA,
	input wire logic DEBOUNCE_EVENT_PIN_ZERO,
	input wire logic DEBOUNCE_EVENT_PIN_ONE,
	input wire logic DEBOUNCE_CLEAR_ENABLE,
	input wire logic DEBOUNCE_ENABLE_PIN_ZERO,
	input wire logic DEBOUNCE_ENABLE_PIN_ONE,
	input wire logic [PERIOD_WIDTH-1:0] DEBOUNCE_PERIOD_FIELD,
	input wire logic TAMPER_EVENT,
	input wire logic DEBOUNCE_STATUS_PIN_ZERO,
	input wire logic DEBOUNCE_STATUS_PIN_ONE,
	output logic WRITES_BLOCKED,
	output logic LOW_HALF_CLEARED
);

	localparam int BANK_AW = 3;
	localparam int NUM_WAKE_PINS = 2;
	localparam logic [`BBK_ADDR_WIDTH-1:0] BANK_END = `BBK_ADDR_WIDTH'(NUM_REGS);

	generate
		if (DATA_WIDTH != 32 || NUM_REGS != 8 || PERIOD_WIDTH < 1) begin : g_bad
			$error("bbk_backup_bank: bank must be eight 32-bit words");
		end
	endgenerate

	// the bank index and every status field must fit the bus
	generate
		if ((1 << BANK_AW) < NUM_REGS
			|| `BBK_ADDR_WIDTH <= BANK_AW
			|| `BBK_STAT_DROP_COUNT_LSB + `BBK_DROP_COUNT_WIDTH > DATA_WIDTH) begin : g_bad_map
			$error("bbk_backup_bank: bank index or status layout does not fit");
		end
	endgenerate

	bbk_pkg::bbk_top_s cur;
	bbk_pkg::bbk_top_s next_cur;

	bbk_pkg::bbk_acc_e acc;
	logic dbc_hit;
	logic clear_req;
	logic write_block;
	logic bank_wr;
	logic bank_rd;
	logic alt_sel;
	logic [DATA_WIDTH-1:0] alt_data;
	logic [DATA_WIDTH-1:0] stat_word;
	logic [NUM_WAKE_PINS-1:0] pin_event;
	logic [NUM_WAKE_PINS-1:0] pin_enable;
	logic [NUM_WAKE_PINS-1:0] pin_flag;
	logic [NUM_WAKE_PINS-1:0] pin_hit;

	// address decode
	always_comb begin
		if (ADDR >= `BBK_OFF_BANK_FIRST && ADDR < BANK_END) begin
			acc = bbk_pkg::BBK_ACC_BANK;
		end else if (ADDR == `BBK_OFF_CTRL) begin
			acc = bbk_pkg::BBK_ACC_CTRL;
		end else if (ADDR == `BBK_OFF_STAT) begin
			acc = bbk_pkg::BBK_ACC_STAT;
		end else begin
			acc = bbk_pkg::BBK_ACC_NONE;
		end
	end

	// per-pin views of the supply controller signals
	assign pin_event = {DEBOUNCE_EVENT_PIN_ONE, DEBOUNCE_EVENT_PIN_ZERO};
	assign pin_enable = {DEBOUNCE_ENABLE_PIN_ONE, DEBOUNCE_ENABLE_PIN_ZERO};
	assign pin_flag = {DEBOUNCE_STATUS_PIN_ONE, DEBOUNCE_STATUS_PIN_ZERO};

	// a pin takes part in the clear only while its debounce is enabled
	generate
		for (genvar p = 0; p < NUM_WAKE_PINS; p++) begin : g_pin
			assign pin_hit[p] = pin_event[p] & pin_enable[p];
		end
	endgenerate

	// debounce clear request from the supply controller configuration
	always_comb begin
		dbc_hit = |pin_hit;
		clear_req = dbc_hit & DEBOUNCE_CLEAR_ENABLE
			& (DEBOUNCE_PERIOD_FIELD != '0) & cur.clr_allow;
	end

	// a tamper arriving with the write already locks it out while a debounce flag is set
	always_comb begin
		write_block = (cur.tamper_seen | TAMPER_EVENT)
			& (|pin_flag);
		bank_wr = WR & (acc == bbk_pkg::BBK_ACC_BANK) & ~write_block;
		bank_rd = RD & (acc == bbk_pkg::BBK_ACC_BANK);
	end

	// status word: live supply controller inputs beside the latched tamper, clear and drop count
	always_comb begin
		stat_word = '0;
		stat_word[`BBK_STAT_BLOCKED_BIT] = write_block;
		stat_word[`BBK_STAT_TAMPER_BIT] = cur.tamper_seen;
		stat_word[`BBK_STAT_CLEARED_BIT] = cur.clear_seen;
		stat_word[`BBK_STAT_CLR_ENABLE_BIT] = DEBOUNCE_CLEAR_ENABLE;
		stat_word[`BBK_STAT_PIN_ZERO_EN_BIT] = DEBOUNCE_ENABLE_PIN_ZERO;
		stat_word[`BBK_STAT_PIN_ONE_EN_BIT] = DEBOUNCE_ENABLE_PIN_ONE;
		stat_word[`BBK_STAT_PERIOD_SET_BIT] = DEBOUNCE_PERIOD_FIELD != '0;
		stat_word[`BBK_STAT_DBC_STATUS_ZERO_BIT] = DEBOUNCE_STATUS_PIN_ZERO;
		stat_word[`BBK_STAT_DBC_STATUS_ONE_BIT] = DEBOUNCE_STATUS_PIN_ONE;
		stat_word[`BBK_STAT_DROP_COUNT_LSB +: `BBK_DROP_COUNT_WIDTH] = cur.drop_count;
	end

	// non-bank read data go through the store's read register
	always_comb begin
		alt_sel = 1'b1;
		alt_data = '0;
		if (acc == bbk_pkg::BBK_ACC_BANK) begin
			alt_sel = 1'b0;
		end else if (acc == bbk_pkg::BBK_ACC_CTRL) begin
			alt_data[`BBK_CTRL_CLR_ALLOW_BIT] = cur.clr_allow;
		end else if (acc == bbk_pkg::BBK_ACC_STAT) begin
			alt_data = stat_word;
		end
	end

	// control state
	always_comb begin
		next_cur = cur;
		next_cur.clear_pulse = clear_req;

		// tamper latch holds until both debounce flags are cleared
		if (TAMPER_EVENT) begin
			next_cur.tamper_seen = 1'b1;
		end else if (pin_flag == '0) begin
			next_cur.tamper_seen = 1'b0;
		end
		// the lock output lags the inputs by one edge; the bus path uses the live condition
		next_cur.blocked = (next_cur.tamper_seen)
			& (|pin_flag);

		// software gate of the debounce clear
		if (WR && acc == bbk_pkg::BBK_ACC_CTRL) begin
			next_cur.clr_allow = WDATA[`BBK_CTRL_CLR_ALLOW_BIT];
		end

		// sticky clear flag: write one clears, a new clear wins
		if (WR && acc == bbk_pkg::BBK_ACC_STAT && WDATA[`BBK_STAT_CLEARED_BIT]) begin
			next_cur.clear_seen = 1'b0;
		end
		if (clear_req) begin
			next_cur.clear_seen = 1'b1;
		end

		// ignored bank writes, saturating
		if (WR && acc == bbk_pkg::BBK_ACC_BANK && write_block
			&& cur.drop_count != `BBK_DROP_COUNT_MAX) begin
			next_cur.drop_count = cur.drop_count + 8'h01;
		end
		// a status write with the clear bit low empties the drop counter
		if (WR && acc == bbk_pkg::BBK_ACC_STAT && !WDATA[`BBK_STAT_CLEARED_BIT]) begin
			next_cur.drop_count = '0;
		end

		if (SYS_RST) begin
			next_cur.tamper_seen = 1'b0;
			next_cur.blocked = 1'b0;
			next_cur.clr_allow = `BBK_CTRL_CLR_ALLOW_RESET;
			next_cur.clear_seen = 1'b0;
			next_cur.clear_pulse = 1'b0;
			next_cur.drop_count = '0;
		end
	end

	always_ff @(posedge CLK) begin
		if (CLK_EN) begin
			cur <= next_cur;
		end
	end

	// reset gates every request so that the retained words survive a system reset
	bbk_store #(
		.WIDTH(DATA_WIDTH),
		.DEPTH(NUM_REGS),
		.AW(BANK_AW)
	) u_store (
		.clk(CLK),
		.rst(SYS_RST),
		.ce(CLK_EN),
		.wr_en(bank_wr & ~SYS_RST),
		.wr_addr(ADDR[BANK_AW-1:0]),
		.wr_data(WDATA),
		.clr_low(clear_req & ~SYS_RST),
		.rd_en(RD & ~SYS_RST),
		.rd_addr(ADDR[BANK_AW-1:0]),
		.alt_sel(alt_sel & ~bank_rd),
		.alt_data(alt_data),
		.rd_data(RDATA)
	);

	assign WRITES_BLOCKED = cur.blocked;
	assign LOW_HALF_CLEARED = cur.clear_pulse;

endmodule

`default_nettype wire

// File: bbk_assertions.sv
// port checker of the backup storage bank
`timescale 1ns/1ns
`default_nettype none
`include "bbk_consts.svh"
module bbk_assertions #(
	parameter int PERIOD_WIDTH = 3
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	input wire logic [3:0] ADDR,
	input wire logic WR,
	input wire logic [31:0] WDATA,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	input wire logic DEBOUNCE_EVENT_PIN_ZERO,
	input wire logic DEBOUNCE_EVENT_PIN_ONE,
	input wire logic DEBOUNCE_CLEAR_ENABLE,
	input wire logic DEBOUNCE_ENABLE_PIN_ZERO,
	input wire logic DEBOUNCE_ENABLE_PIN_ONE,
	input wire logic [PERIOD_WIDTH-1:0] DEBOUNCE_PERIOD_FIELD,
	input wire logic TAMPER_EVENT,
	input wire logic DEBOUNCE_STATUS_PIN_ZERO,
	input wire logic DEBOUNCE_STATUS_PIN_ONE,
	input wire logic WRITES_BLOCKED,
	input wire logic LOW_HALF_CLEARED
);
	wire logic clr;
	wire logic flag;
	logic gate_open;
	// software gate of the debounce clear, followed from the bus
	always_ff @(posedge CLK) begin
		if (CLK_EN) begin
			if (SYS_RST) begin
				gate_open <= `BBK_CTRL_CLR_ALLOW_RESET;
			end else if (WR && ADDR == `BBK_OFF_CTRL) begin
				gate_open <= WDATA[`BBK_CTRL_CLR_ALLOW_BIT];
			end
		end
	end
	assign clr = ((DEBOUNCE_EVENT_PIN_ZERO & DEBOUNCE_ENABLE_PIN_ZERO) | (DEBOUNCE_EVENT_PIN_ONE
		& DEBOUNCE_ENABLE_PIN_ONE)) & DEBOUNCE_CLEAR_ENABLE & (|DEBOUNCE_PERIOD_FIELD) & gate_open;
	assign flag = DEBOUNCE_STATUS_PIN_ZERO | DEBOUNCE_STATUS_PIN_ONE;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST || !CLK_EN);
	property p_rd_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	property p_clr; clr |=> LOW_HALF_CLEARED; endproperty
	a_clr: assert property (p_clr) else $error("clear missed");
	property p_clr_cause; LOW_HALF_CLEARED |-> $past(clr); endproperty
	a_clr_cause: assert property (p_clr_cause) else $error("clear without cause");
	property p_clr_read; LOW_HALF_CLEARED && RD && ADDR < 4'h4 |=> RDATA == 32'h0; endproperty
	a_clr_read: assert property (p_clr_read) else $error("cleared word not zero");
	property p_block; TAMPER_EVENT && flag |=> WRITES_BLOCKED; endproperty
	a_block: assert property (p_block) else $error("lock missed");
	property p_unblock; !TAMPER_EVENT && !flag |=> !WRITES_BLOCKED; endproperty
	a_unblock: assert property (p_unblock) else $error("lock held");
endmodule
bind bbk_backup_bank bbk_assertions #(.PERIOD_WIDTH(PERIOD_WIDTH)) bbk_assertions_inst (.*);
`default_nettype wire

// File: bbk_supply.sv
// behavioural supply controller: debounce events, debounce flags, tamper
`timescale 1ns/1ns
`default_nettype none
module bbk_supply (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] wake,
	input wire logic tamp,
	input wire logic ack,
	output logic [1:0] ev,
	output logic [1:0] st,
	output logic tamper
);
	logic [1:0] seen;
	always_ff @(posedge clk) begin
		if (rst) begin
			{seen, ev, st, tamper} <= '0;
		end else begin
			seen <= wake;
			ev <= wake & ~seen;
			// flags stay until software acknowledges them
			st <= ack ? 2'b00 : st | (wake & ~seen);
			tamper <= tamp;
		end
	end
endmodule
`default_nettype wire

// File: bbk_tb.sv
// self-checking testbench of the backup storage bank
`timescale 1ns/1ns
`default_nettype none
`include "bbk_consts.svh"
module testbench;
	logic CLK, SYS_RST, CLK_EN, WR, RD, tamp, ack;
	logic DEBOUNCE_CLEAR_ENABLE, DEBOUNCE_ENABLE_PIN_ZERO, DEBOUNCE_ENABLE_PIN_ONE;
	logic [3:0] ADDR;
	logic [31:0] WDATA;
	logic [2:0] DEBOUNCE_PERIOD_FIELD;
	logic [1:0] wake;
	wire logic [31:0] RDATA;
	wire logic DEBOUNCE_EVENT_PIN_ZERO, DEBOUNCE_EVENT_PIN_ONE, TAMPER_EVENT, WRITES_BLOCKED, LOW_HALF_CLEARED;
	wire logic DEBOUNCE_STATUS_PIN_ZERO, DEBOUNCE_STATUS_PIN_ONE;
	int errors = 0;
	int check_count = 0;
	bbk_backup_bank bbk_backup_bank_inst (.*);
	bbk_supply bbk_supply_inst (.clk(CLK), .rst(SYS_RST), .wake(wake), .tamp(tamp), .ack(ack),
		.ev({DEBOUNCE_EVENT_PIN_ONE, DEBOUNCE_EVENT_PIN_ZERO}),
		.st({DEBOUNCE_STATUS_PIN_ONE, DEBOUNCE_STATUS_PIN_ZERO}), .tamper(TAMPER_EVENT));
	function automatic logic [31:0] wv(input logic [31:0] b, input int i);
		return b + 32'(i) * 32'h1111_1111;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge CLK) begin
			ADDR <= a;
			WDATA <= d;
			WR <= 1'b1;
		end
		@(posedge CLK) WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge CLK) begin
			ADDR <= a;
			RD <= 1'b1;
		end
		@(posedge CLK) RD <= 1'b0;
		#1 chk(RDATA, e);
	endtask
	task automatic fill(input logic [31:0] b);
		for (int i = 0; i < 8; i++) wr(4'(i), wv(b, i));
	endtask
	task automatic t_words;
		fill(32'h5a00_0000);
		for (int i = 0; i < 8; i++) rd(4'(i), wv(32'h5a00_0000, i));
		rd(4'hf, 32'h0);
		$display("test words done");
	endtask
	task automatic t_clear(input int p, input logic [1:0] en, input logic ce, input logic [2:0] pr, input logic g);
		logic hit;
		hit = en[p] & ce & (pr != 3'h0) & g;
		fill(32'hc0de_0000);
		@(posedge CLK) begin
			wake[p] <= 1'b1;
			{DEBOUNCE_ENABLE_PIN_ONE, DEBOUNCE_ENABLE_PIN_ZERO} <= en;
			DEBOUNCE_CLEAR_ENABLE <= ce;
			DEBOUNCE_PERIOD_FIELD <= pr;
		end
		@(posedge CLK);
		// read word 0 in the cycle of the clear pulse
		@(posedge CLK) begin
			ADDR <= 4'h0;
			RD <= 1'b1;
		end
		#1 chk(32'(LOW_HALF_CLEARED), 32'(hit));
		@(posedge CLK) RD <= 1'b0;
		#1 chk(RDATA, hit ? 32'h0 : wv(32'hc0de_0000, 0));
		chk(32'(LOW_HALF_CLEARED), 32'h0);
		for (int i = 1; i < 8; i++) rd(4'(i), (hit && i < 4) ? 32'h0 : wv(32'hc0de_0000, i));
		@(posedge CLK) wake <= 2'b00;
		$display("test clear pin %0d done", p);
	endtask
	task automatic t_tamper;
		wr(4'h5, 32'h0000_aaaa);
		rd(4'h5, 32'h0000_aaaa);
		@(posedge CLK) tamp <= 1'b1;
		@(posedge CLK) tamp <= 1'b0;
		wr(4'h5, 32'h0000_bbbb);
		rd(4'h5, 32'h0000_aaaa);
		chk(32'(WRITES_BLOCKED), 32'h1);
		@(posedge CLK) ack <= 1'b1;
		@(posedge CLK) ack <= 1'b0;
		wr(4'h5, 32'h0000_bbbb);
		rd(4'h5, 32'h0000_bbbb);
		chk(32'(WRITES_BLOCKED), 32'h0);
		$display("test tamper done");
	endtask
	task automatic t_regs;
		rd(`BBK_OFF_STAT, 32'h0001_006c);
		wr(`BBK_OFF_STAT, 32'h0000_0004);
		rd(`BBK_OFF_STAT, 32'h0001_0068);
		wr(`BBK_OFF_STAT, 32'h0000_0000);
		rd(`BBK_OFF_STAT, 32'h0000_0068);
		rd(`BBK_OFF_CTRL, 32'h0000_0001);
		wr(`BBK_OFF_CTRL, 32'h0000_0000);
		rd(`BBK_OFF_CTRL, 32'h0000_0000);
		t_clear(0, 2'b01, 1'b1, 3'h2, 1'b0);
		rd(`BBK_OFF_STAT, 32'h0000_00d8);
		wr(`BBK_OFF_CTRL, 32'h0000_0001);
		rd(`BBK_OFF_CTRL, 32'h0000_0001);
		$display("test registers done");
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	initial begin
		{SYS_RST, CLK_EN} = 2'b11;
		{WR, RD, tamp, ack, wake, ADDR, WDATA} = '0;
		{DEBOUNCE_CLEAR_ENABLE, DEBOUNCE_ENABLE_PIN_ZERO, DEBOUNCE_ENABLE_PIN_ONE, DEBOUNCE_PERIOD_FIELD} = '0;
		repeat (6) @(posedge CLK);
		SYS_RST <= 1'b0;
		t_words;
		t_clear(0, 2'b01, 1'b1, 3'h1, 1'b1);
		t_clear(1, 2'b10, 1'b1, 3'h7, 1'b1);
		t_clear(0, 2'b01, 1'b0, 3'h1, 1'b1);
		t_clear(1, 2'b11, 1'b1, 3'h0, 1'b1);
		t_clear(0, 2'b10, 1'b1, 3'h1, 1'b1);
		t_tamper;
		t_regs;
		end_of_test;
	end
endmodule
`default_nettype wire
